// *** rtl/tlsc_lo_ctrl.sv ***
// Purpose: LO tuning controller, synthesizer dividers, filter and bypass
//          control of a satellite tuner.
// Assumes: All inputs synchronous to core_clk_i; vvar_code_i is a sampled
//          varactor voltage; lo_pulse_i is one pulse per prescaler cycle.
// Notes:   Contract
// Contract
// - Bypass follows only its own bit; power-down and sleep never touch it.
// - Bypass enabled after reset; cleared enable powers it down.
// - Five-bit filter reference ratio 4..27 divides the crystal clock.
// - Six-bit filter bandwidth code, usable range 0..62.
// - Cutoff = fxtal / ratio * (code + 1) / 1.257 in the analogue filter.
// - Three oscillators of sixteen sub-bands, chosen automatically by default.
// - Prescale divide-by-4 or divide-by-2 picked per oscillator by itself.
// - Auto-band-disable stops band switching; host band is used.
// - Varactor sampled at selectable rate, default comparison rate / 8.
// - Window thresholds default, or host high/low fields via window select.
// - Lock window widens after failed hunting unless relax enable is 0.
// - Lock flag from time-averaged phase comparison; readable in status.
// - Lock pin pulls low only inside unlock window with lock flag set.
// - Lock window centred in unlock window; hysteresis holds the band.
// - Master clear returns LO control to initial conditions.
// - 15-bit M*16+A main divider with 16/17 prescaler control.
// - Reference divider with 29 selectable ratios makes comparison rate.
// - Phase/frequency comparator runs with comparison rate up to 2 MHz.
// - Charge pump current fixed or scaled by sub-band, host's choice.
// - Analogue power-down when sleep pin or power-down bit is high.
// - Status bit 6 is the lock flag.
`timescale 1ns/1ns
module tlsc_lo_ctrl
  import tlsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_i,
  input wire logic power_down_bit_i,
  input wire logic rf_bypass_wr_i,
  input wire logic rf_bypass_en_i,
  input wire logic [4:0] filter_ref_divide_ratio_i,
  input wire logic [5:0] filter_bandwidth_code_i,
  input wire logic auto_band_disable_i,
  input wire logic [1:0] manual_osc_sel_i,
  input wire logic [3:0] manual_sub_band_i,
  input wire logic [2:0] window_sample_rate_i,
  input wire logic window_select_i,
  input wire logic [2:0] window_high_threshold_i,
  input wire logic [2:0] window_low_threshold_i,
  input wire logic window_relax_enable_i,
  input wire logic lo_master_clear_i,
  input wire logic [14:0] main_div_ratio_i,
  input wire logic [4:0] ref_div_sel_i,
  input wire logic [2:0] cp_current_i,
  input wire logic cp_auto_scale_i,
  input wire logic lo_pulse_i,
  input wire logic [5:0] vvar_code_i,
  output logic analog_power_down_o,
  output logic rf_bypass_power_down_o,
  output logic [4:0] filter_ref_divide_ratio_o,
  output logic [5:0] filter_bandwidth_code_o,
  output logic filter_ref_tick_o,
  output logic comp_tick_o,
  output logic main_div_tick_o,
  output logic prescaler_mod17_o,
  output logic pfd_up_o,
  output logic pfd_dn_o,
  output logic [2:0] cp_current_o,
  output logic [1:0] osc_sel_o,
  output logic [3:0] sub_band_o,
  output logic lo_prescale_ratio_o,
  output logic freq_lock_flag_o,
  output logic [7:0] status_byte_o,
  output logic lock_pin_o,
  output logic lock_pin_oe_n_o
);

  tlsc_regs_t r;
  tlsc_regs_t n;

  // ----------------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] ref_sel, ref_ratio;
    logic [10:0] m_val, smp_div;
    logic [3:0] a_val;
    logic sample, in_lock, above_lock;
    logic [2:0] wh, wl;
    logic [6:0] lock_off_hi, lock_off_lo, lock_hi, lock_lo;
    logic [6:0] unl_hi, unl_lo, v;
    logic [1:0] man_osc;
    logic [3:0] cp_sum;
    tlsc_regs_t keep;
    ref_sel = '0;
    ref_ratio = '0;
    m_val = '0;
    a_val = '0;
    smp_div = '0;
    sample = 1'b0;
    wh = '0;
    wl = '0;
    lock_off_hi = '0;
    lock_off_lo = '0;
    lock_hi = '0;
    lock_lo = '0;
    unl_hi = '0;
    unl_lo = '0;
    v = '0;
    in_lock = 1'b0;
    above_lock = 1'b0;
    man_osc = '0;
    cp_sum = '0;
    keep = '0;
    n = r;

    // Bypass enable is its own register, so sleep cannot reach it
    if (rf_bypass_wr_i) begin
      n.bypass_en = rf_bypass_en_i;
    end

    // --------------------------------------------------------------------
    // Filter FLL reference divider
    // --------------------------------------------------------------------
    // Out-of-range ratios are clamped so the divider never stalls
    if (filter_ref_divide_ratio_i < TLSC_FLT_RATIO_MIN) begin
      n.flt_ratio = TLSC_FLT_RATIO_MIN;
    end else if (filter_ref_divide_ratio_i > TLSC_FLT_RATIO_MAX) begin
      n.flt_ratio = TLSC_FLT_RATIO_MAX;
    end else begin
      n.flt_ratio = filter_ref_divide_ratio_i;
    end
    if (filter_bandwidth_code_i > TLSC_FLT_BW_MAX) begin
      n.flt_bw = TLSC_FLT_BW_MAX;
    end else begin
      n.flt_bw = filter_bandwidth_code_i;
    end
    n.flt_tick = (r.flt_cnt >= r.flt_ratio - 5'h01);
    n.flt_cnt = n.flt_tick ? 5'h00 : r.flt_cnt + 5'h01;

    // --------------------------------------------------------------------
    // Reference divider to comparison rate
    // --------------------------------------------------------------------
    ref_sel = (ref_div_sel_i > TLSC_REF_SEL_MAX) ? TLSC_REF_SEL_MAX
                                                 : ref_div_sel_i;
    ref_ratio = TLSC_REF_RATIO_MIN + ref_sel;
    n.comp_tick = (r.ref_cnt >= ref_ratio - 5'h01);
    n.ref_cnt = n.comp_tick ? 5'h00 : r.ref_cnt + 5'h01;

    // --------------------------------------------------------------------
    // Main divider, M counts prescaler cycles, first A use modulus 17
    // --------------------------------------------------------------------
    m_val = main_div_ratio_i[14:TLSC_A_BITS];
    a_val = main_div_ratio_i[TLSC_A_BITS-1:0];
    n.div_tick = 1'b0;
    if (lo_pulse_i) begin
      if (r.m_cnt + 11'h001 >= m_val) begin
        n.m_cnt = '0;
        n.a_cnt = '0;
        n.div_tick = 1'b1;
      end else begin
        n.m_cnt = r.m_cnt + 11'h001;
        if (r.a_cnt != 4'hf) begin
          n.a_cnt = r.a_cnt + 4'h1;
        end
      end
    end
    n.mod17 = (n.a_cnt < a_val);

    // --------------------------------------------------------------------
    // Phase/frequency detector and averaged lock flag
    // --------------------------------------------------------------------
    n.pfd_up = r.pfd_up | r.comp_tick;
    n.pfd_dn = r.pfd_dn | r.div_tick;
    if (n.pfd_up && n.pfd_dn) begin
      n.pfd_up = 1'b0;
      n.pfd_dn = 1'b0;
    end
    if ((r.pfd_up ^ r.pfd_dn) && (r.err_cnt != 8'hff)) begin
      n.err_cnt = r.err_cnt + 8'h01;
    end
    // One decision per comparison period gives the time average
    if (r.comp_tick) begin
      n.err_cnt = '0;
      if (r.err_cnt <= TLSC_LOCK_ERR_MAX) begin
        if (r.lock_avg != TLSC_LOCK_AVG_MAX) begin
          n.lock_avg = r.lock_avg + 4'h1;
        end
      end else if (r.lock_avg != 4'h0) begin
        n.lock_avg = r.lock_avg - 4'h1;
      end
    end
    if (r.lock_avg == TLSC_LOCK_AVG_MAX) begin
      n.fl = 1'b1;
    end else if (r.lock_avg < TLSC_LOCK_AVG_LOSE) begin
      n.fl = 1'b0;
    end

    // --------------------------------------------------------------------
    // Varactor windows
    // --------------------------------------------------------------------
    wh = window_select_i ? window_high_threshold_i : TLSC_DEF_WH;
    wl = window_select_i ? window_low_threshold_i : TLSC_DEF_WL;
    lock_off_hi = 7'h01 + {4'h0, wh} + TLSC_RELAX_STEP * {5'h00, r.relax};
    lock_off_lo = 7'h01 + {4'h0, wl} + TLSC_RELAX_STEP * {5'h00, r.relax};
    lock_hi = TLSC_VMID + lock_off_hi;
    lock_lo = TLSC_VMID - lock_off_lo;
    // Same margin on both sides keeps the lock window centred
    unl_hi = lock_hi + TLSC_UNLOCK_MARGIN;
    unl_lo = lock_lo - TLSC_UNLOCK_MARGIN;
    v = {1'b0, vvar_code_i};
    in_lock = (v <= lock_hi) && (v >= lock_lo);
    above_lock = (v > lock_hi);

    // --------------------------------------------------------------------
    // Sample timing, default one sample per eight comparisons
    // --------------------------------------------------------------------
    smp_div = TLSC_SMP_BASE_DIV << window_sample_rate_i;
    if (r.comp_tick) begin
      if (r.smp_cnt + 11'h001 >= smp_div) begin
        n.smp_cnt = '0;
        sample = 1'b1;
      end else begin
        n.smp_cnt = r.smp_cnt + 11'h001;
      end
    end

    // --------------------------------------------------------------------
    // Band selection
    // --------------------------------------------------------------------
    if (sample) begin
      if (v > unl_hi) begin
        n.tu = TLSC_TU_ABOVE;
      end else if (v < unl_lo) begin
        n.tu = TLSC_TU_BELOW;
      end else begin
        n.tu = TLSC_TU_IN;
      end
    end
    if (!window_relax_enable_i) begin
      n.relax = '0;
    end
    if (auto_band_disable_i) begin
      man_osc = (manual_osc_sel_i > TLSC_OSC_MAX) ? TLSC_OSC_MAX
                                                 : manual_osc_sel_i;
      n.band = {man_osc, manual_sub_band_i};
      n.st = TLSC_HUNT;
      n.miss_cnt = '0;
    end else if (sample) begin
      case (r.st)
        TLSC_HUNT: begin
          if (in_lock) begin
            n.st = TLSC_HOLD;
            n.miss_cnt = '0;
          end else begin
            if (above_lock && (r.band != TLSC_BAND_MAX)) begin
              n.band = r.band + 6'h01;
            end else if (!above_lock && (r.band != 6'h00)) begin
              n.band = r.band - 6'h01;
            end
            if (r.miss_cnt == TLSC_RELAX_MISSES) begin
              n.miss_cnt = '0;
              if (window_relax_enable_i && (r.relax != TLSC_RELAX_MAX)) begin
                n.relax = r.relax + 2'h1;
              end
            end else begin
              n.miss_cnt = r.miss_cnt + 6'h01;
            end
          end
        end
        TLSC_HOLD: begin
          // Only leaving the wider window restarts hunting
          if ((v > unl_hi) || (v < unl_lo)) begin
            n.st = TLSC_HUNT;
          end
        end
        default: n.st = TLSC_HUNT;
      endcase
    end
    n.prescale = TLSC_PRESCALE_DIV2[n.band[5:4]];

    // --------------------------------------------------------------------
    // Charge pump and lock pin
    // --------------------------------------------------------------------
    cp_sum = {1'b0, cp_current_i} + {2'h0, n.band[3:2]};
    if (!cp_auto_scale_i) begin
      n.cp_cur = cp_current_i;
    end else if (cp_sum > {1'b0, TLSC_CP_MAX}) begin
      n.cp_cur = TLSC_CP_MAX;
    end else begin
      n.cp_cur = cp_sum[2:0];
    end
    n.lock_drive = (r.tu == TLSC_TU_IN) && r.fl;

    // Master clear resets LO control only; host settings and the filter
    // divider carry on, so a write in the same cycle is not lost
    if (lo_master_clear_i) begin
      keep = n;
      n = TLSC_RST;
      n.bypass_en = keep.bypass_en;
      n.flt_ratio = keep.flt_ratio;
      n.flt_bw = keep.flt_bw;
      n.ref_cnt = keep.ref_cnt;
      n.flt_cnt = keep.flt_cnt;
      n.flt_tick = keep.flt_tick;
      n.cp_cur = keep.cp_cur;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= TLSC_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign analog_power_down_o = sleep_i | power_down_bit_i;
  assign rf_bypass_power_down_o = ~r.bypass_en;
  assign filter_ref_divide_ratio_o = r.flt_ratio;
  assign filter_bandwidth_code_o = r.flt_bw;
  assign filter_ref_tick_o = r.flt_tick;
  assign comp_tick_o = r.comp_tick;
  assign main_div_tick_o = r.div_tick;
  assign prescaler_mod17_o = r.mod17;
  assign pfd_up_o = r.pfd_up;
  assign pfd_dn_o = r.pfd_dn;
  assign cp_current_o = r.cp_cur;
  assign osc_sel_o = r.band[5:4];
  assign sub_band_o = r.band[3:0];
  assign lo_prescale_ratio_o = r.prescale;
  assign freq_lock_flag_o = r.fl;
  // Power-on indicator is kept by the serial interface, not here
  assign status_byte_o = {1'b0, r.fl, r.band[3:0], r.tu};
  assign lock_pin_o = 1'b0;
  assign lock_pin_oe_n_o = ~r.lock_drive;

endmodule : tlsc_lo_ctrl

// *** rtl/tlsc_pkg.sv ***
// Purpose: Shared constants and types for the tuner LO tuning control block.
// Assumes: Core clock is the crystal reference, 125 MHz.
// Notes:   Window thresholds are in varactor ADC codes (6 bits).
package tlsc_pkg;
  // --------------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------------
  localparam logic [4:0] TLSC_REF_RATIO_MIN = 5'h02;
  localparam logic [4:0] TLSC_REF_SEL_MAX = 5'h1c;
  localparam logic [4:0] TLSC_FLT_RATIO_MIN = 5'h04;
  localparam logic [4:0] TLSC_FLT_RATIO_MAX = 5'h1b;
  localparam logic [5:0] TLSC_FLT_BW_MAX = 6'h3e;
  localparam int TLSC_A_BITS = 4;
  localparam int TLSC_M_BITS = 11;
  // --------------------------------------------------------------------
  // Lock detection and sampling
  // --------------------------------------------------------------------
  localparam logic [7:0] TLSC_LOCK_ERR_MAX = 8'h02;
  localparam logic [3:0] TLSC_LOCK_AVG_MAX = 4'hf;
  localparam logic [3:0] TLSC_LOCK_AVG_LOSE = 4'h4;
  localparam logic [10:0] TLSC_SMP_BASE_DIV = 11'h008;
  localparam logic [5:0] TLSC_BAND_MAX = 6'h2f;
  localparam logic [1:0] TLSC_OSC_MAX = 2'h2;
  localparam logic [2:0] TLSC_PRESCALE_DIV2 = 3'h4;
  localparam logic [2:0] TLSC_CP_MAX = 3'h7;
  // --------------------------------------------------------------------
  // Windows
  // --------------------------------------------------------------------
  localparam logic [6:0] TLSC_VMID = 7'h20;
  localparam logic [2:0] TLSC_DEF_WH = 3'h3;
  localparam logic [2:0] TLSC_DEF_WL = 3'h3;
  localparam logic [6:0] TLSC_UNLOCK_MARGIN = 7'h08;
  localparam logic [6:0] TLSC_RELAX_STEP = 7'h02;
  localparam logic [1:0] TLSC_RELAX_MAX = 2'h3;
  localparam logic [5:0] TLSC_RELAX_MISSES = 6'h3f;
  localparam logic [1:0] TLSC_TU_IN = 2'h0;
  localparam logic [1:0] TLSC_TU_ABOVE = 2'h1;
  localparam logic [1:0] TLSC_TU_BELOW = 2'h2;
  localparam int TLSC_FL_BIT = 6;

  typedef enum logic [0:0] {
    TLSC_HUNT = 1'b0,
    TLSC_HOLD = 1'b1
  } tlsc_state_t;

  typedef struct packed {
    logic [4:0] ref_cnt;
    logic comp_tick;
    logic [4:0] flt_cnt;
    logic flt_tick;
    logic [3:0] a_cnt;
    logic [10:0] m_cnt;
    logic div_tick;
    logic mod17;
    logic pfd_up;
    logic pfd_dn;
    logic [7:0] err_cnt;
    logic [3:0] lock_avg;
    logic fl;
    logic [10:0] smp_cnt;
    logic [5:0] band;
    tlsc_state_t st;
    logic [1:0] relax;
    logic [5:0] miss_cnt;
    logic [1:0] tu;
    logic lock_drive;
    logic prescale;
    logic bypass_en;
    logic [4:0] flt_ratio;
    logic [5:0] flt_bw;
    logic [2:0] cp_cur;
  } tlsc_regs_t;

  localparam tlsc_regs_t TLSC_RST = '{
    bypass_en: 1'b1,
    flt_ratio: TLSC_FLT_RATIO_MIN,
    st: TLSC_HUNT,
    default: '0
  };
endpackage : tlsc_pkg

// *** verification/tlsc_lo_ctrl_props.sv ***
// Purpose: Port-level assertions for the LO tuning control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
module tlsc_lo_ctrl_props
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_i,
  input wire logic power_down_bit_i,
  input wire logic rf_bypass_wr_i,
  input wire logic rf_bypass_en_i,
  input wire logic [4:0] filter_ref_divide_ratio_i,
  input wire logic [5:0] filter_bandwidth_code_i,
  input wire logic auto_band_disable_i,
  input wire logic [1:0] manual_osc_sel_i,
  input wire logic [3:0] manual_sub_band_i,
  input wire logic lo_master_clear_i,
  input wire logic [2:0] cp_current_i,
  input wire logic cp_auto_scale_i,
  input wire logic analog_power_down_o,
  input wire logic rf_bypass_power_down_o,
  input wire logic [4:0] filter_ref_divide_ratio_o,
  input wire logic [5:0] filter_bandwidth_code_o,
  input wire logic pfd_up_o,
  input wire logic pfd_dn_o,
  input wire logic [2:0] cp_current_o,
  input wire logic [1:0] osc_sel_o,
  input wire logic [3:0] sub_band_o,
  input wire logic lo_prescale_ratio_o,
  input wire logic freq_lock_flag_o,
  input wire logic [7:0] status_byte_o,
  input wire logic lock_pin_o,
  input wire logic lock_pin_oe_n_o
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  bypass_write_a: assert property (
    rf_bypass_wr_i |=> rf_bypass_power_down_o == !$past(rf_bypass_en_i))
    else $error("bypass state not taken from write");
  bypass_hold_a: assert property (
    !rf_bypass_wr_i |=> $stable(rf_bypass_power_down_o))
    else $error("bypass changed without a write");
  analog_pd_a: assert property (
    analog_power_down_o == (sleep_i | power_down_bit_i))
    else $error("analogue power-down mismatch");
  flt_ratio_a: assert property (1'b1 |=>
    filter_ref_divide_ratio_o == (($past(filter_ref_divide_ratio_i) < 5'h04)
    ? 5'h04 : ($past(filter_ref_divide_ratio_i) > 5'h1b) ? 5'h1b
    : $past(filter_ref_divide_ratio_i)))
    else $error("filter ratio not clamped");
  flt_bw_a: assert property (1'b1 |=> filter_bandwidth_code_o ==
    (($past(filter_bandwidth_code_i) > 6'h3e) ? 6'h3e
    : $past(filter_bandwidth_code_i)))
    else $error("bandwidth code not clamped");
  cp_fixed_a: assert property (
    !cp_auto_scale_i && !lo_master_clear_i |=>
    cp_current_o == $past(cp_current_i))
    else $error("fixed pump current not kept");
  manual_band_a: assert property (
    auto_band_disable_i && !lo_master_clear_i |=>
    sub_band_o == $past(manual_sub_band_i) && osc_sel_o ==
    (($past(manual_osc_sel_i) == 2'h3) ? 2'h2 : $past(manual_osc_sel_i)))
    else $error("manual band not applied");
  prescale_sel_a: assert property (
    $stable(osc_sel_o) |-> lo_prescale_ratio_o == (osc_sel_o == 2'h2))
    else $error("prescale ratio does not follow oscillator");
  lock_pin_a: assert property (!lo_master_clear_i |=>
    !lock_pin_oe_n_o == ($past(freq_lock_flag_o) &&
    $past(status_byte_o[1:0]) == 2'h0))
    else $error("lock pin drive mismatch");
  lock_level_a: assert property (
    !lock_pin_oe_n_o |-> !lock_pin_o)
    else $error("lock pin driven high");
  status_map_a: assert property (
    status_byte_o[7:2] == {1'b0, freq_lock_flag_o, sub_band_o})
    else $error("status byte layout mismatch");
  master_clr_a: assert property (
    lo_master_clear_i |=> !freq_lock_flag_o && lock_pin_oe_n_o)
    else $error("master clear left lock state");
  pfd_excl_a: assert property (
    !(pfd_up_o && pfd_dn_o))
    else $error("both comparator outputs set");
  lock_pin_c: cover property (!lock_pin_oe_n_o);
  bypass_off_c: cover property (rf_bypass_wr_i && !rf_bypass_en_i);
  clear_c: cover property (freq_lock_flag_o ##1 lo_master_clear_i);
endmodule : tlsc_lo_ctrl_props

bind tlsc_lo_ctrl tlsc_lo_ctrl_props i_tlsc_lo_ctrl_props (.*);

// *** verification/tlsc_vco_model.sv ***
// Purpose: Behavioural oscillator side: prescaler pulses and varactor code.
// Assumes: Pulses every second core clock while running.
// Notes:   Stands still (no pulses) while run_i is low.
`timescale 1ns/1ns
module tlsc_vco_model
(
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic [5:0] vvar_set_i,
  output logic lo_pulse_o,
  output logic [5:0] vvar_code_o
);
  logic ph_r = 1'b0;
  // Rising edge update acts as a register: run_i set at the falling edge
  // is taken without a race and each pulse lasts one whole cycle
  always @(posedge core_clk_i) begin
    ph_r <= run_i & ~ph_r;
  end
  assign lo_pulse_o = ph_r;
  assign vvar_code_o = vvar_set_i;
endmodule : tlsc_vco_model

// *** verification/test_tlsc_lo_ctrl.sv ***
// Purpose: Self-checking bench for the LO tuning control block.
// Assumes: 125 MHz core clock, inputs driven on the falling edge.
// Notes:   Fixed seed; corner values mixed into the random loop.
`timescale 1ns/1ns
module test_tlsc_lo_ctrl;
  logic core_clk_i, rst_n_i, sleep_i, power_down_bit_i, rf_bypass_wr_i;
  logic rf_bypass_en_i, auto_band_disable_i, window_select_i, run, bpd;
  logic window_relax_enable_i, lo_master_clear_i, cp_auto_scale_i;
  logic lo_pulse_i, analog_power_down_o, rf_bypass_power_down_o;
  logic filter_ref_tick_o, comp_tick_o, main_div_tick_o, prescaler_mod17_o;
  logic pfd_up_o, pfd_dn_o, lo_prescale_ratio_o, freq_lock_flag_o;
  logic lock_pin_o, lock_pin_oe_n_o;
  logic [1:0] manual_osc_sel_i, osc_sel_o;
  logic [2:0] window_sample_rate_i, window_high_threshold_i;
  logic [2:0] window_low_threshold_i, cp_current_i, cp_current_o;
  logic [3:0] manual_sub_band_i, sub_band_o, b0;
  logic [4:0] filter_ref_divide_ratio_i, ref_div_sel_i;
  logic [4:0] filter_ref_divide_ratio_o;
  logic [5:0] filter_bandwidth_code_i, vvar_code_i, vvar_set;
  logic [5:0] filter_bandwidth_code_o;
  logic [7:0] status_byte_o;
  logic [14:0] main_div_ratio_i;
  logic [4:0] sels [4] = '{5'h00, 5'h05, 5'h1c, 5'h1f};
  int n_errors = 0, checked = 0, g, i, nd, nf;
  tlsc_lo_ctrl i_tlsc_lo_ctrl (.*);
  tlsc_vco_model i_tlsc_vco_model (.core_clk_i(core_clk_i), .run_i(run),
    .vvar_set_i(vvar_set), .lo_pulse_o(lo_pulse_i),
    .vvar_code_o(vvar_code_i));
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic [4:0] exp_ratio(input logic [4:0] r);
    return (r < 5'h04) ? 5'h04 : (r > 5'h1b) ? 5'h1b : r;
  endfunction : exp_ratio
  // Clocks until the comparison tick is next seen, after syncing to one
  task automatic tick_gap(output int n);
    n = 0;
    while (comp_tick_o !== 1'b1 && n < 99) begin
      @(negedge core_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (comp_tick_o !== 1'b1 && n < 99);
  endtask : tick_gap
  task automatic wait_band(output int n);
    b0 = sub_band_o;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (sub_band_o === b0 && n < 500);
  endtask : wait_band
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    {rst_n_i, sleep_i, power_down_bit_i, rf_bypass_wr_i, run} = '0;
    {rf_bypass_en_i, auto_band_disable_i, window_select_i} = '0;
    {window_relax_enable_i, lo_master_clear_i, cp_auto_scale_i} = '0;
    {manual_osc_sel_i, manual_sub_band_i, window_sample_rate_i} = '0;
    {window_high_threshold_i, cp_current_i, filter_bandwidth_code_i} = '0;
    window_low_threshold_i = 3'h3;
    filter_ref_divide_ratio_i = 5'h04;
    ref_div_sel_i = 5'h00;
    main_div_ratio_i = 15'h0020;
    vvar_set = 6'h20;
    bpd = 1'b0;
    g = $urandom(51780);
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk(rf_bypass_power_down_o, 0);
    chk(lock_pin_oe_n_o, 1);
    chk(freq_lock_flag_o, 0);
    for (i = 0; i < 64; i++) begin
      filter_ref_divide_ratio_i = (i < 32) ? 5'(i) : 5'($urandom);
      filter_bandwidth_code_i = (i > 59) ? 6'(i) : 6'($urandom);
      {sleep_i, power_down_bit_i} = 2'($urandom);
      rf_bypass_wr_i = ($urandom % 4) == 0;
      rf_bypass_en_i = 1'($urandom);
      if (rf_bypass_wr_i)
        bpd = !rf_bypass_en_i;
      #1 chk(analog_power_down_o, sleep_i | power_down_bit_i);
      @(negedge core_clk_i);
      chk(rf_bypass_power_down_o, bpd);
      chk(filter_ref_divide_ratio_o, exp_ratio(filter_ref_divide_ratio_i));
      chk(filter_bandwidth_code_o, (filter_bandwidth_code_i > 6'h3e) ?
        6'h3e : filter_bandwidth_code_i);
    end
    rf_bypass_wr_i = 1'b0;
    $display("test controls done");
    for (i = 0; i < 4; i++) begin
      ref_div_sel_i = sels[i];
      tick_gap(g);
      chk(16'(g), ((sels[i] > 5'h1c) ? 16'h1c : sels[i]) + 16'h2);
    end
    $display("test reference divider done");
    ref_div_sel_i = 5'h02;
    vvar_set = 6'h25;
    window_select_i = 1'b1;
    window_high_threshold_i = 3'h7;
    // Restart hunting so that the window choice alone decides the band
    lo_master_clear_i = 1'b1;
    @(negedge core_clk_i);
    lo_master_clear_i = 1'b0;
    repeat (150) @(negedge core_clk_i);
    chk(sub_band_o, 0);
    chk(status_byte_o[1:0], 0);
    window_select_i = 1'b0;
    repeat (150) @(negedge core_clk_i);
    chk(sub_band_o, 0);
    vvar_set = 6'h30;
    wait_band(g);
    wait_band(g);
    chk(16'(g), 32);
    chk({status_byte_o[1:0], sub_band_o}, {2'h1, b0 + 4'h1});
    window_sample_rate_i = 3'h1;
    vvar_set = 6'h08;
    wait_band(g);
    wait_band(g);
    chk(16'(g), 64);
    chk({status_byte_o[1:0], sub_band_o}, {2'h2, b0 - 4'h1});
    $display("test band hunting done");
    auto_band_disable_i = 1'b1;
    cp_auto_scale_i = 1'b1;
    cp_current_i = 3'h6;
    for (i = 0; i < 4; i++) begin
      manual_osc_sel_i = 2'(i);
      manual_sub_band_i = 4'($urandom);
      repeat (2) @(negedge core_clk_i);
      chk({osc_sel_o, sub_band_o}, {(i == 3) ? 2'h2 : 2'(i),
        manual_sub_band_i});
      chk(lo_prescale_ratio_o, i > 1);
      chk(cp_current_o, (manual_sub_band_i[3:2] > 0) ? 3'h7 : 3'h6);
    end
    {auto_band_disable_i, cp_auto_scale_i, window_sample_rate_i} = '0;
    $display("test manual band done");
    vvar_set = 6'h20;
    filter_ref_divide_ratio_i = 5'h05;
    filter_bandwidth_code_i = 6'h00;
    // Start the oscillator just after a comparison tick so that both
    // comparator inputs line up and the averaged flag can settle
    while (comp_tick_o !== 1'b1) @(negedge core_clk_i);
    run = 1'b1;
    g = 0;
    while (freq_lock_flag_o !== 1'b1 && g < 600) begin
      @(negedge core_clk_i);
      g++;
    end
    chk(status_byte_o[6], 1);
    nd = 0;
    nf = 0;
    repeat (40) begin
      @(negedge core_clk_i);
      nd += main_div_tick_o;
      nf += filter_ref_tick_o;
    end
    chk(16'(nd), 16'h000a);
    chk(16'(nf), 16'h0008);
    chk(lock_pin_oe_n_o, 0);
    vvar_set = 6'h30;
    repeat (40) @(negedge core_clk_i);
    chk(lock_pin_oe_n_o, 1);
    lo_master_clear_i = 1'b1;
    @(negedge core_clk_i);
    lo_master_clear_i = 1'b0;
    chk({freq_lock_flag_o, sub_band_o}, 0);
    $display("test lock and clear done");
    print_verdict();
  end
endmodule : test_tlsc_lo_ctrl
